// [xsd_cfg.svh]
// Constants of the side-bus peripheral select decoder
`ifndef XSD_CFG_SVH
`define XSD_CFG_SVH

// Clock rates and the bus clock divider derived from them
`define XSD_CLK_HZ          25000000
`define XSD_BUS_CLK_HZ      8333333
`define XSD_BUS_DIV         (`XSD_CLK_HZ / `XSD_BUS_CLK_HZ)

// Index and data ports of the configuration space
`define XSD_PORT_INDEX      16'h0022
`define XSD_PORT_DATA       16'h0023

// Configuration register indices
`define XSD_IDX_SEL_EN_A    8'h4E
`define XSD_IDX_SEL_EN_B    8'h4F
`define XSD_IDX_GP0_LO      8'h64
`define XSD_IDX_GP0_HI      8'h65
`define XSD_IDX_GP0_MASK    8'h66
`define XSD_IDX_GP1_LO      8'h68
`define XSD_IDX_GP1_HI      8'h69
`define XSD_IDX_GP1_MASK    8'h6A
`define XSD_IDX_GP2_LO      8'h6C
`define XSD_IDX_GP2_HI      8'h6D
`define XSD_IDX_GP2_MASK    8'h6E
`define XSD_IDX_GP_BUS_CTL  8'h6F

// Reset values
`define XSD_RST_SEL_EN_A    8'hFF
`define XSD_RST_SEL_EN_B    8'h01
`define XSD_RST_GP          8'h00
`define XSD_RST_INDEX       8'h00

// Bit positions in enable register A
`define XSD_BIT_KBD         0
`define XSD_BIT_CLOCK_CHIP  1
`define XSD_BIT_FLOPPY      2
`define XSD_BIT_DISK0       3
`define XSD_BIT_DISK1       4
`define XSD_BIT_PRINTER     5
`define XSD_BIT_SERIAL1     6
`define XSD_BIT_SERIAL2     7
// Bit positions in enable register B
`define XSD_BIT_CFG_RAM     0
`define XSD_BIT_GP0         1

// Fixed decode values and care masks (one bits are compared)
`define XSD_A_KBD0          16'h0060
`define XSD_A_KBD1          16'h0064
`define XSD_M_KBD           16'hFFFD
`define XSD_A_CLK_LATCH     16'h0070
`define XSD_A_CLK_DATA      16'h0071
`define XSD_M_CLK           16'hFFF9
`define XSD_A_DISK0_S       16'h0170
`define XSD_A_DISK0_P       16'h01F0
`define XSD_M_DISK0         16'hFFF8
`define XSD_A_DISK1_S       16'h0376
`define XSD_A_DISK1_P       16'h03F6
`define XSD_M_DISK1         16'hFFFE
`define XSD_A_PRN3          16'h0278
`define XSD_A_PRN2          16'h0378
`define XSD_A_PRN1          16'h03BC
`define XSD_M_PRN           16'hFFFC
`define XSD_A_SER2          16'h02F8
`define XSD_A_SER1          16'h03F8
`define XSD_M_SER           16'hFFF8
`define XSD_A_FLOP_S_LO     16'h0370
`define XSD_A_FLOP_S_HI     16'h0375
`define XSD_A_FLOP_S_X      16'h0377
`define XSD_A_FLOP_P_LO     16'h03F0
`define XSD_A_FLOP_P_HI     16'h03F5
`define XSD_A_FLOP_P_X      16'h03F7
`define XSD_A_CFG_RAM       16'h0800
`define XSD_M_CFG_RAM       16'hFF00

`endif

// [xsd_pkg.sv]
// Types and decode helpers of the side-bus peripheral select decoder
`default_nettype none
package xsd_pkg;

  // Encoded select values
  typedef enum logic [2:0] {
    XSD_ESEL_SER1 = 3'b000,
    XSD_ESEL_SER2 = 3'b001,
    XSD_ESEL_PRN  = 3'b010,
    XSD_ESEL_DSK0 = 3'b011,
    XSD_ESEL_DSK1 = 3'b100,
    XSD_ESEL_IDLE = 3'b111
  } xsd_esel_e;

  typedef logic [7:0] xsd_byte_t;

  // Compare an address against a value in the bits of a care mask
  function automatic logic xsd_hit(input logic [15:0] addr,
                                   input logic [15:0] val,
                                   input logic [15:0] care);
    xsd_hit = ((addr ^ val) & care) == 16'h0000;
  endfunction

  // Inclusive address range test
  function automatic logic xsd_in(input logic [15:0] addr,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    xsd_in = (addr >= lo) && (addr <= hi);
  endfunction

endpackage
`default_nettype wire

// [xsd_reg_if.sv]
// Carrier between the decoder and its configuration register file
`default_nettype none
interface xsd_reg_if #(parameter int NREG = 12);
  logic                  wr_en;
  logic [7:0]            wr_idx;
  logic [7:0]            wr_data;
  logic [7:0]            rd_idx;
  logic [7:0]            rd_data;
  logic [NREG-1:0][7:0]  regs;

  modport owner (input wr_en, input wr_idx, input wr_data, input rd_idx,
                 output rd_data, output regs);
  modport user  (output wr_en, output wr_idx, output wr_data,
                 output rd_idx, input rd_data, input regs);
endinterface
`default_nettype wire

// [xsd_regmem.sv]
// Configuration register file with registered read data
`include "xsd_cfg.svh"
`default_nettype none
module xsd_regmem
  import xsd_pkg::*;
#(
  parameter int NREG = 12
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  xsd_reg_if.owner   rif
);

  // Index and reset value of each implemented register
  localparam logic [11:0][7:0] IDX = {
    `XSD_IDX_GP_BUS_CTL, `XSD_IDX_GP2_MASK, `XSD_IDX_GP2_HI,
    `XSD_IDX_GP2_LO,     `XSD_IDX_GP1_MASK, `XSD_IDX_GP1_HI,
    `XSD_IDX_GP1_LO,     `XSD_IDX_GP0_MASK, `XSD_IDX_GP0_HI,
    `XSD_IDX_GP0_LO,     `XSD_IDX_SEL_EN_B, `XSD_IDX_SEL_EN_A};
  localparam logic [11:0][7:0] RST = {
    {10{`XSD_RST_GP}}, `XSD_RST_SEL_EN_B, `XSD_RST_SEL_EN_A};

  // Refuse a register count the index table cannot serve
  if (NREG != 12) begin : g_bad_nreg
    $error("xsd_regmem serves exactly 12 registers");
  end

  // One byte register per implemented index
  for (genvar i = 0; i < 12; i++) begin : g_reg
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        rif.regs[i] <= RST[i];
      end else if (rif.wr_en && rif.wr_idx == IDX[i]) begin
        rif.regs[i] <= rif.wr_data;
      end
    end
  end

  // Registered readback; unimplemented indices read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rif.rd_data <= 8'h00;
    end else begin
      rif.rd_data <= 8'h00;
      for (int j = 0; j < 12; j++) begin
        if (rif.rd_idx == IDX[j]) rif.rd_data <= rif.regs[j];
      end
    end
  end

endmodule
`default_nettype wire

// [xsd_decoder.sv]
// Side-bus peripheral select decoder with configuration index port
//
// What this block does
// - Every peripheral select follows the latched address with no clock.
// - Clock-chip and config-RAM strobes come from decode, command, bus tick.
// - Fixed peripherals decode at fixed addresses, general purpose ones not.
// - Two enable registers switch each fixed peripheral's decode off.
// - Three general purpose selects each have base low, base high and mask.
// - Keyboard select covers 0060h and 0064h with address bit 1 ignored.
// - Clock-chip latch pulses on writes to 0070h, strobes on 0071h.
// - Encoded value 011 is driven for 0170h-0177h and 01F0h-01F7h.
// - Encoded value 100 is driven for 0376h, 0377h, 03F6h and 03F7h.
// - Encoded value 010 covers 0278h-027Bh, 0378h-037Bh and 03BCh-03BFh.
// - Encoded value 00x covers 02F8h-02FFh and 03F8h-03FFh, one per port.
// - Floppy select covers 0370h-0375h, 03F0h-03F5h, 0377h and 03F7h.
// - Config-RAM strobes fire for any I/O access in 0800h-08FFh.
`include "xsd_cfg.svh"
`default_nettype none
module xsd_decoder
  import xsd_pkg::*;
#(
  parameter int BUS_DIV = `XSD_BUS_DIV,
  parameter int NGP     = 3
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_read_n,
  input  wire logic        io_write_n,
  input  wire logic [7:0]  io_data_in,
  output logic      [7:0]  io_data_out,
  output logic             io_data_oe_n,
  output logic             keyboard_sel_n,
  output logic             floppy_sel_n,
  output logic      [2:0]  encoded_sel,
  output logic             disk0_sel_n,
  output logic             disk1_sel_n,
  output logic             printer_port_sel_n,
  output logic      [1:0]  serial_port_sel_n,
  output logic      [2:0]  gp_sel_n,
  output logic             clock_chip_addr_latch,
  output logic             clock_chip_write_n,
  output logic             clock_chip_read_n,
  output logic             cfg_ram_write_n,
  output logic             cfg_ram_read_n
);

  // Refuse parameter values the decode logic cannot serve
  if (BUS_DIV < 2 || BUS_DIV > 255) begin : g_bad_div
    $error("BUS_DIV out of range");
  end
  if (NGP != 3) begin : g_bad_ngp
    $error("NGP must be 3");
  end

  xsd_reg_if #(.NREG(12)) rif ();

  xsd_regmem #(.NREG(12)) u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .rif   (rif)
  );

  // Configuration port and bus clock state
  logic [7:0]  index_q;
  logic        wr_prev_q;
  logic [7:0]  div_q;
  logic        bus_tick;
  logic        io_cyc;
  logic        io_rd;
  logic        io_wr;
  logic        wr_take;
  xsd_byte_t   en_a;
  xsd_byte_t   en_b;

  // Decode terms of the fixed and programmable selects
  logic        kbd_hit;
  logic        flop_hit;
  logic        clk_latch_hit;
  logic        clk_data_hit;
  logic        cram_hit;
  logic [2:0]  gp_hit;
  logic        disk0_hit;
  logic        disk1_hit;
  logic        prn_hit;
  logic        ser1_hit;
  logic        ser2_hit;
  xsd_esel_e   esel;

  // Registered outputs
  logic [7:0]  dout_q;
  logic        oe_n_q;
  logic        ale_q;
  logic        cwr_n_q;
  logic        crd_n_q;
  logic        rwr_n_q;
  logic        rrd_n_q;

  assign io_rd   = !io_read_n;
  assign io_wr   = !io_write_n;
  assign io_cyc  = io_rd || io_wr;
  assign en_a    = rif.regs[0];
  assign en_b    = rif.regs[1];
  assign wr_take = io_wr && wr_prev_q;

  // Bus clock enable from the system clock divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(BUS_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign bus_tick = (div_q == 8'(BUS_DIV - 1));

  // Write command edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= io_write_n;
    end
  end

  // Index port holds the configuration register number
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_q <= `XSD_RST_INDEX;
    end else if (wr_take && io_addr == `XSD_PORT_INDEX) begin
      index_q <= io_data_in;
    end
  end

  // Data port writes and reads the indexed register
  assign rif.wr_en   = wr_take && io_addr == `XSD_PORT_DATA;
  assign rif.wr_idx  = index_q;
  assign rif.wr_data = io_data_in;
  assign rif.rd_idx  = index_q;

  // Read data toward the bus: the index at 22h, the register at 23h
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= 8'h00;
    end else begin
      dout_q <= (io_addr == `XSD_PORT_INDEX) ? index_q : rif.rd_data;
    end
  end

  // Output enable goes low the clock after a port read is seen and rises the clock after it ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= !(io_rd && (io_addr == `XSD_PORT_INDEX ||
                            io_addr == `XSD_PORT_DATA));
    end
  end
  assign io_data_out  = dout_q;
  assign io_data_oe_n = oe_n_q;

  // Either of two windows that share one care mask
  function automatic logic pair_hit(input logic [15:0] addr,
                                    input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic [15:0] care);
    pair_hit = xsd_hit(addr, a, care) || xsd_hit(addr, b, care);
  endfunction

  // Fixed-address hits, each gated by its enable; keyboard and floppy also by an I/O command
  always_comb begin
    kbd_hit = io_cyc && en_a[`XSD_BIT_KBD] &&
              pair_hit(io_addr, `XSD_A_KBD0, `XSD_A_KBD1,
                       `XSD_M_KBD);
    flop_hit = io_cyc && en_a[`XSD_BIT_FLOPPY] &&
               (xsd_in(io_addr, `XSD_A_FLOP_S_LO, `XSD_A_FLOP_S_HI) ||
                xsd_in(io_addr, `XSD_A_FLOP_P_LO, `XSD_A_FLOP_P_HI) ||
                io_addr == `XSD_A_FLOP_S_X ||
                io_addr == `XSD_A_FLOP_P_X);
    clk_latch_hit = en_a[`XSD_BIT_CLOCK_CHIP] &&
                    xsd_hit(io_addr, `XSD_A_CLK_LATCH, `XSD_M_CLK);
    clk_data_hit = en_a[`XSD_BIT_CLOCK_CHIP] &&
                   xsd_hit(io_addr, `XSD_A_CLK_DATA, `XSD_M_CLK);
    cram_hit = en_b[`XSD_BIT_CFG_RAM] &&
               xsd_hit(io_addr, `XSD_A_CFG_RAM, `XSD_M_CFG_RAM);
  end

  // Programmable general purpose hits
  for (genvar g = 0; g < 3; g++) begin : g_gp
    logic [15:0] base;
    logic [15:0] care;
    assign base = {rif.regs[3*g+3], rif.regs[3*g+2]};
    assign care = {8'hFF, ~rif.regs[3*g+4]};
    assign gp_hit[g] = io_cyc && en_b[`XSD_BIT_GP0 + g] &&
                       xsd_hit(io_addr, base, care);
  end

  // Encoded-select windows, each gated by its enable
  always_comb begin
    disk0_hit = en_a[`XSD_BIT_DISK0] &&
                pair_hit(io_addr, `XSD_A_DISK0_S, `XSD_A_DISK0_P,
                         `XSD_M_DISK0);
    disk1_hit = en_a[`XSD_BIT_DISK1] &&
                pair_hit(io_addr, `XSD_A_DISK1_S, `XSD_A_DISK1_P,
                         `XSD_M_DISK1);
    prn_hit   = en_a[`XSD_BIT_PRINTER] &&
                (xsd_hit(io_addr, `XSD_A_PRN3, `XSD_M_PRN) ||
                 xsd_hit(io_addr, `XSD_A_PRN2, `XSD_M_PRN) ||
                 xsd_hit(io_addr, `XSD_A_PRN1, `XSD_M_PRN));
    ser1_hit  = en_a[`XSD_BIT_SERIAL1] &&
                xsd_hit(io_addr, `XSD_A_SER1, `XSD_M_SER);
    ser2_hit  = en_a[`XSD_BIT_SERIAL2] &&
                xsd_hit(io_addr, `XSD_A_SER2, `XSD_M_SER);
  end

  // Encoded select; idle when nothing enabled matches
  always_comb begin
    esel = XSD_ESEL_IDLE;
    if (io_cyc) begin
      if (disk0_hit) begin
        esel = XSD_ESEL_DSK0;
      end else if (disk1_hit) begin
        esel = XSD_ESEL_DSK1;
      end else if (prn_hit) begin
        esel = XSD_ESEL_PRN;
      end else if (ser1_hit) begin
        esel = XSD_ESEL_SER1;
      end else if (ser2_hit) begin
        esel = XSD_ESEL_SER2;
      end
    end
  end

  // Combinational selects straight from the address
  assign encoded_sel        = esel;
  assign keyboard_sel_n     = !kbd_hit;
  assign floppy_sel_n       = !flop_hit;
  assign gp_sel_n           = ~gp_hit;

  // Individual selects decoded from the encoded value
  assign disk0_sel_n        = (esel != XSD_ESEL_DSK0);
  assign disk1_sel_n        = (esel != XSD_ESEL_DSK1);
  assign printer_port_sel_n = (esel != XSD_ESEL_PRN);
  assign serial_port_sel_n  = {esel != XSD_ESEL_SER2,
                               esel != XSD_ESEL_SER1};

  // Clock-chip address latch, sampled on the bus clock tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ale_q <= 1'b0;
    end else if (bus_tick) begin
      ale_q <= io_wr && clk_latch_hit;
    end
  end

  // Clock-chip write strobe, sampled on the bus clock tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cwr_n_q <= 1'b1;
    end else if (bus_tick) begin
      cwr_n_q <= !(io_wr && clk_data_hit);
    end
  end

  // Clock-chip read strobe, sampled on the bus clock tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crd_n_q <= 1'b1;
    end else if (bus_tick) begin
      crd_n_q <= !(io_rd && clk_data_hit);
    end
  end

  // Config-RAM write strobe, sampled on the bus clock tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rwr_n_q <= 1'b1;
    end else if (bus_tick) begin
      rwr_n_q <= !(io_wr && cram_hit);
    end
  end

  // Config-RAM read strobe, sampled on the bus clock tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rrd_n_q <= 1'b1;
    end else if (bus_tick) begin
      rrd_n_q <= !(io_rd && cram_hit);
    end
  end
  assign clock_chip_addr_latch = ale_q;
  assign clock_chip_write_n    = cwr_n_q;
  assign clock_chip_read_n     = crd_n_q;
  assign cfg_ram_write_n       = rwr_n_q;
  assign cfg_ram_read_n        = rrd_n_q;

endmodule
`default_nettype wire

// [xsd_decoder_properties.sv]
// Pin-level checks for the side-bus select decoder
`default_nettype none
module xsd_decoder_properties (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] io_addr,
  input wire logic        io_read_n,
  input wire logic        io_write_n,
  input wire logic        keyboard_sel_n,
  input wire logic        floppy_sel_n,
  input wire logic [2:0]  encoded_sel,
  input wire logic [2:0]  gp_sel_n,
  input wire logic        clock_chip_addr_latch,
  input wire logic        clock_chip_read_n,
  input wire logic        cfg_ram_write_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Decode terms worked out from the address and the command pins
  logic cmd;
  logic flop_hit;
  assign cmd = !io_read_n || !io_write_n;
  assign flop_hit = (io_addr[15:4] == 12'h037 || io_addr[15:4] == 12'h03F)
    && (io_addr[3:0] <= 4'h5 || io_addr[3:0] == 4'h7);
  // A config-RAM write held through a whole bus tick period
  sequence cram_wr_held;
    (!io_write_n && io_addr[15:8] == 8'h08) [*3];
  endsequence
  kbd_decode_a:
    assert property (!keyboard_sel_n |->
      cmd && (io_addr & 16'hFFF9) == 16'h0060)
    else $error("keyboard select off its addresses");
  floppy_decode_a:
    assert property (!floppy_sel_n |-> cmd && flop_hit)
    else $error("floppy select off its addresses");
  disk0_code_a:
    assert property (encoded_sel == 3'h3 |-> (io_addr & 16'hFFF8) == 16'h0170
      || (io_addr & 16'hFFF8) == 16'h01F0) else $error("disk0 code misplaced");
  disk1_code_a:
    assert property (encoded_sel == 3'h4 |-> (io_addr & 16'hFFFE) == 16'h0376
      || (io_addr & 16'hFFFE) == 16'h03F6) else $error("disk1 code misplaced");
  printer_code_a:
    assert property (encoded_sel == 3'h2 |-> (io_addr & 16'hFFFC) == 16'h0278
      || (io_addr & 16'hFFFC) == 16'h0378 || (io_addr & 16'hFFFC) == 16'h03BC)
    else $error("printer code misplaced");
  serial_code_a:
    assert property (encoded_sel[2:1] == 2'h0 |-> (io_addr & 16'hFFF8) ==
      (encoded_sel[0] ? 16'h02F8 : 16'h03F8))
    else $error("serial code misplaced");
  idle_selects_a:
    assert property (!cmd |-> encoded_sel == 3'h7 && keyboard_sel_n
      && floppy_sel_n && gp_sel_n == 3'h7)
    else $error("select without command");
  latch_cause_a:
    assert property ($rose(clock_chip_addr_latch) |-> !$past(io_write_n)
      && (($past(io_addr) & 16'hFFF9) == 16'h0070))
    else $error("stray latch");
  clk_read_cause_a:
    assert property ($fell(clock_chip_read_n) |-> !$past(io_read_n)
      && (($past(io_addr) & 16'hFFF9) == 16'h0071))
    else $error("stray read");
  cram_write_a:
    assert property (cram_wr_held |=> !cfg_ram_write_n)
    else $error("config RAM write strobe missing");
endmodule
bind xsd_decoder xsd_decoder_properties u_props (
  .clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_read_n(io_read_n),
  .io_write_n(io_write_n), .keyboard_sel_n(keyboard_sel_n),
  .floppy_sel_n(floppy_sel_n), .encoded_sel(encoded_sel),
  .gp_sel_n(gp_sel_n), .clock_chip_addr_latch(clock_chip_addr_latch),
  .clock_chip_read_n(clock_chip_read_n), .cfg_ram_write_n(cfg_ram_write_n));
`default_nettype wire

// [xsd_periph_model.sv]
// Side-bus peripheral stand-in that counts the strobes it receives
`default_nettype none
module xsd_periph_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       latch,
  input  wire logic       cram_wr_n,
  output logic      [7:0] latch_cnt,
  output logic      [7:0] cram_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic latch_q;
  logic cram_wr_n_q;
  // Count each latch pulse and each config-RAM write once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q     <= 1'b0;
      cram_wr_n_q <= 1'b1;
      latch_cnt   <= 8'h00;
      cram_cnt    <= 8'h00;
    end else begin
      latch_q     <= latch;
      cram_wr_n_q <= cram_wr_n;
      if (latch && !latch_q) latch_cnt <= latch_cnt + 8'h01;
      if (!cram_wr_n && cram_wr_n_q) cram_cnt <= cram_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [xsd_decoder_bench.sv]
// Self-checking bench for the side-bus select decoder
`default_nettype none
module xsd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, io_read_n, io_write_n, io_data_oe_n;
  logic [15:0] io_addr;
  logic [7:0]  io_data_in, io_data_out, latch_cnt, cram_cnt;
  logic        keyboard_sel_n, floppy_sel_n, disk0_sel_n, disk1_sel_n;
  logic        printer_port_sel_n, clock_chip_addr_latch;
  logic        clock_chip_write_n, clock_chip_read_n;
  logic        cfg_ram_write_n, cfg_ram_read_n;
  logic [2:0]  encoded_sel, gp_sel_n;
  logic [1:0]  serial_port_sel_n;
  int          mismatches, comparisons, cycles;
  // Probe addresses and expected {keyboard, floppy, encoded} selects
  localparam logic [15:0] TA [17] = '{16'h0062, 16'h0066, 16'h0068,
    16'h0177, 16'h01F0, 16'h0178, 16'h0377, 16'h03F6, 16'h0375, 16'h027B,
    16'h03BC, 16'h037C, 16'h02FF, 16'h03F8, 16'h03F7, 16'h0376, 16'h0370};
  localparam logic [4:0] TE [17] = '{5'h0F, 5'h0F, 5'h1F, 5'h1B, 5'h1B,
    5'h1F, 5'h14, 5'h1C, 5'h17, 5'h1A, 5'h1A, 5'h1F, 5'h19, 5'h18, 5'h14,
    5'h1C, 5'h17};
  xsd_decoder dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
    .io_read_n(io_read_n), .io_write_n(io_write_n), .io_data_in(io_data_in),
    .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
    .keyboard_sel_n(keyboard_sel_n), .floppy_sel_n(floppy_sel_n),
    .encoded_sel(encoded_sel), .disk0_sel_n(disk0_sel_n),
    .disk1_sel_n(disk1_sel_n), .printer_port_sel_n(printer_port_sel_n),
    .serial_port_sel_n(serial_port_sel_n), .gp_sel_n(gp_sel_n),
    .clock_chip_addr_latch(clock_chip_addr_latch),
    .clock_chip_write_n(clock_chip_write_n),
    .clock_chip_read_n(clock_chip_read_n),
    .cfg_ram_write_n(cfg_ram_write_n), .cfg_ram_read_n(cfg_ram_read_n));
  xsd_periph_model u_model (.clk(clk), .rst_b(rst_b),
    .latch(clock_chip_addr_latch), .cram_wr_n(cfg_ram_write_n),
    .latch_cnt(latch_cnt), .cram_cnt(cram_cnt));
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Present an I/O command and hold it across a full bus tick period
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_data_in = d;
    io_write_n = !w;
    io_read_n = w;
    repeat (4) @(negedge clk);
  endtask
  task automatic idle;
    io_read_n = 1'b1;
    io_write_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    cyc(16'h0022, 1'b1, i);
    idle;
    cyc(16'h0023, 1'b1, d);
    idle;
  endtask
  task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
    cyc(16'h0022, 1'b1, i);
    idle;
    cyc(16'h0023, 1'b0, 8'h00);
    chk(io_data_out, e);
    chk(8'(io_data_oe_n), 8'h00);
    idle;
  endtask
  // Compare all fixed selects against one expectation
  task automatic sel_chk(input logic [15:0] a, input logic w,
                         input logic [4:0] e);
    cyc(a, w, 8'h00);
    chk({3'h0, keyboard_sel_n, floppy_sel_n, encoded_sel}, {3'h0, e});
    chk({3'h0, disk0_sel_n, disk1_sel_n, printer_port_sel_n,
         serial_port_sel_n},
      {3'h0, e[2:0] != 3'h3, e[2:0] != 3'h4, e[2:0] != 3'h2, e[2:0] != 3'h1,
       e[2:0] != 3'h0});
    idle;
  endtask
  initial begin
    rst_b = 1'b0;
    io_addr = 16'h0000;
    io_read_n = 1'b1;
    io_write_n = 1'b1;
    io_data_in = 8'h00;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // Register reset values and an unmapped index
    cfg_rd(8'h4E, 8'hFF);
    cfg_rd(8'h4F, 8'h01);
    cfg_rd(8'h6C, 8'h00);
    cfg_wr(8'h41, 8'h5A);
    cfg_rd(8'h41, 8'h00);
    // The index port reads back the last index written
    cyc(16'h0022, 1'b0, 8'h00);
    chk(io_data_out, 8'h41);
    idle;
    chk(8'(io_data_oe_n), 8'h01);
    // Select follows the address before any clock edge
    @(negedge clk);
    io_addr = 16'h0064;
    io_read_n = 1'b0;
    #1 chk(8'(keyboard_sel_n), 8'h00);
    @(negedge clk);
    idle;
    // No command means no select
    io_addr = 16'h0060;
    @(negedge clk);
    chk({3'h0, keyboard_sel_n, floppy_sel_n, encoded_sel}, 8'h1F);
    // Fixed decode table, reads and writes alternating
    for (int i = 0; i < 17; i++) begin
      sel_chk(TA[i], i[0], TE[i]);
    end
    // Enables switch fixed decodes off
    cfg_wr(8'h4E, 8'h00);
    sel_chk(16'h0060, 1'b0, 5'h1F);
    sel_chk(16'h03F8, 1'b0, 5'h1F);
    cyc(16'h0070, 1'b1, 8'h00);
    chk(8'(clock_chip_addr_latch), 8'h00);
    idle;
    cfg_wr(8'h4E, 8'hFF);
    // Clock-chip and config-RAM strobes
    cyc(16'h0076, 1'b1, 8'h00);
    chk(8'(clock_chip_addr_latch), 8'h01);
    idle;
    chk(8'(clock_chip_addr_latch), 8'h00);
    cyc(16'h0071, 1'b0, 8'h00);
    chk(8'(clock_chip_read_n), 8'h00);
    idle;
    cyc(16'h0075, 1'b1, 8'h00);
    chk(8'(clock_chip_write_n), 8'h00);
    idle;
    cyc(16'h08FF, 1'b1, 8'h00);
    chk(8'(cfg_ram_write_n), 8'h00);
    idle;
    cyc(16'h0800, 1'b0, 8'h00);
    chk(8'(cfg_ram_read_n), 8'h00);
    idle;
    chk(latch_cnt, 8'h01);
    chk(cram_cnt, 8'h01);
    // General purpose selects: base 03x0h, low two bits masked
    cfg_wr(8'h4F, 8'h0F);
    for (int i = 0; i < 3; i++) begin
      cfg_wr(8'(8'h64 + 4 * i), 8'(16 * i));
      cfg_wr(8'(8'h65 + 4 * i), 8'h03);
      cfg_wr(8'(8'h66 + 4 * i), 8'h03);
    end
    cfg_rd(8'h6A, 8'h03);
    for (int i = 0; i < 3; i++) begin
      cyc(16'(16'h0302 + 16 * i), 1'b0, 8'h00);
      chk({5'h00, gp_sel_n}, {5'h00, 3'(~(3'h1 << i))});
      idle;
    end
    cyc(16'h0304, 1'b1, 8'h00);
    chk({5'h00, gp_sel_n}, 8'h07);
    idle;
    cyc(16'h0403, 1'b0, 8'h00);
    chk({5'h00, gp_sel_n}, 8'h07);
    idle;
    wrap_up;
  end
endmodule
`default_nettype wire
